// ### pgtc_pkg.sv
package pgtc_pkg;
   // Register word indices; the byte address of a register is four times its index
   localparam logic [7:0] MON1_LEVEL_IDX = 8'h14;
   localparam logic [7:0] MON2_SUPPLY_IDX = 8'h15;
   localparam logic [7:0] CONV_WINDOW_IDX = 8'h16;
   localparam logic [7:0] GOOD_CTRL_IDX = 8'h17;
   localparam logic [7:0] OTP_CTRL_IDX = 8'h1C;
   localparam int ADDR_W = 10;
   // Reset values of the registers before the OTP image lands
   localparam logic [7:0] MON1_LEVEL_RST = 8'h00;
   localparam logic [7:0] MON2_SUPPLY_RST = 8'h00;
   localparam logic [7:0] CONV_WINDOW_RST = 8'h00;
   localparam logic [7:0] GOOD_CTRL_RST = 8'h02;
   // Field positions
   localparam int WIN_LO = 3;
   localparam int HI_WIN_LO = 6;
   localparam int ANA_LEVEL_POS = 5;
   localparam int BOOST_LEVEL_LO = 4;
   localparam int B_WIN_LO = 2;
   localparam int A_WIN_LO = 0;
   localparam int GOOD_B_BEH_POS = 7;
   localparam int GOOD_B_GATE_POS = 6;
   localparam int GOOD_B_POL_POS = 4;
   localparam int GOOD_A_BEH_POS = 3;
   localparam int GOOD_A_GATE_POS = 2;
   localparam int GOOD_A_DRV_POS = 1;
   localparam int GOOD_A_POL_POS = 0;
   // Writable mask of the control register: bit 5 is reserved
   localparam logic [7:0] GOOD_CTRL_MASK = 8'hDF;
   localparam logic [7:0] MON1_MASK = 8'h1F;

   // OTP default image, one byte for each level/control register
   typedef struct packed {
      logic [7:0] mon1;
      logic [7:0] mon2Supply;
      logic [7:0] convWindow;
      logic [7:0] goodCtrl;
   } pgtc_otp_t;

   // Register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pgtc_bus_req_t;

   // Decoded settings for the analog comparators
   typedef struct packed {
      logic [1:0] mon1WindowWidth;
      logic [2:0] mon1NominalLevel;
      logic mon1DividerEn;
      logic [1:0] analogSupplyWindowWidth;
      logic analogSupplyNominalLevel;
      logic [1:0] mon2WindowWidth;
      logic [2:0] mon2NominalLevel;
      logic mon2DividerEn;
      logic [1:0] boostWindowWidth;
      logic [1:0] boostLevel;
      logic [1:0] stepDownBWindowWidth;
      logic [1:0] stepDownAWindowWidth;
   } pgtc_analog_t;

   // Decoded power-good output controls
   typedef struct packed {
      logic goodBBehaviour;
      logic goodBLatchedGating;
      logic goodBPolarity;
      logic goodABehaviour;
      logic goodALatchedGating;
      logic goodADriveType;
      logic goodAPolarity;
   } pgtc_good_t;

endpackage

// ### pgtc_regs.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
// Behaviour
// - Monitor A window bits 4-3: codes 0..3 give 2, 3, 4, 6 percent.
// - Monitor A level bits 2-0: codes 0..6 give 0.65 to 1.80 V.
// - Nonzero level code enables internal divider; zero leaves input high impedance.
// - Analog supply window bits 7-6: 4, 5, 10, 10 percent.
// - Analog supply level bit 5: clear is 3.3 V, set is 5.0 V.
// - Monitor B window bits 4-3 share monitor A's four-step encoding.
// - Monitor B level bits 2-0 as monitor A; code 7 also 1.80 V.
// - Boost window bits 7-6: 2, 4, 6, 8 percent.
// - Step-down B window bits 3-2: 30, 50, 70, 90 mV.
// - Step-down A window bits 1-0: 30, 50, 70, 90 mV.
// - Control register: B mode, gating, reserved, polarity; A mode, gating, type, polarity.
// - After reset fields hold constants until the OTP image is valid, then load its defaults.
// - Polarity clear drives output high when valid; set drives it low.
module pgtc_regs
   import pgtc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire pgtc_pkg::pgtc_bus_req_t busReq,
   output logic [31:0] rdData,
   input wire pgtc_pkg::pgtc_otp_t otpImage,
   input wire logic otpValid,
   input wire logic goodAValid,
   input wire logic goodBValid,
   output pgtc_pkg::pgtc_analog_t analogCfg,
   output pgtc_pkg::pgtc_good_t goodCfg,
   output logic [6:0] mon1WindowPct,
   output logic [7:0] mon1Level10mV,
   output logic [6:0] mon2WindowPct,
   output logic [7:0] mon2Level10mV,
   output logic [6:0] anaWindowPct,
   output logic [8:0] anaLevel10mV,
   output logic [6:0] boostWindowPct,
   output logic [6:0] stepDownBWindowMv,
   output logic [6:0] stepDownAWindowMv,
   output logic goodOutputA,
   output logic goodOutputB,
   output logic goodOutputAOe,
   output logic otpLoaded
);
   import pgtc_pkg::*;

   // All state of the block: registers, synchroniser, read data and registered outputs
   typedef struct packed {
      logic [7:0] mon1;
      logic [7:0] mon2Supply;
      logic [7:0] convWindow;
      logic [7:0] goodCtrl;
      logic otpDone;
      logic otpValidSync1;
      logic otpValidSync2;
      logic reloadReq;
      logic [31:0] rdData;
      pgtc_analog_t analog;
      pgtc_good_t good;
      logic [6:0] mon1Win;
      logic [7:0] mon1Lvl;
      logic [6:0] mon2Win;
      logic [7:0] mon2Lvl;
      logic [6:0] anaWin;
      logic [8:0] anaLvl;
      logic [6:0] boostWin;
      logic [6:0] bWin;
      logic [6:0] aWin;
      logic goodA;
      logic goodB;
      logic goodAOe;
   } pgtc_state_t;

   pgtc_state_t state_q;
   pgtc_state_t state_d;

   // Drive level of a power-good pin: polarity clear means high when valid
   function automatic logic goodLevel(input logic valid, input logic polarity);
      return valid ^ polarity;
   endfunction

   // Word index match on a byte address
   function automatic logic hitIdx(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      return (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
   endfunction

   // Monitor window code to percent; both monitor inputs share this encoding
   function automatic logic [6:0] decodeMonWindow(input logic [1:0] code);
      case (code)
         2'h0: return 7'h02;
         2'h1: return 7'h03;
         2'h2: return 7'h04;
         2'h3: return 7'h06;
         default: return 7'h00;
      endcase
   endfunction

   // Analog supply window code to percent; the two top codes give the same width
   function automatic logic [6:0] decodeAnaWindow(input logic [1:0] code);
      case (code)
         2'h0: return 7'h04;
         2'h1: return 7'h05;
         2'h2, 2'h3: return 7'h0A;
         default: return 7'h00;
      endcase
   endfunction

   // Boost window code to percent
   function automatic logic [6:0] decodeBoostWindow(input logic [1:0] code);
      case (code)
         2'h0: return 7'h02;
         2'h1: return 7'h04;
         2'h2: return 7'h06;
         2'h3: return 7'h08;
         default: return 7'h00;
      endcase
   endfunction

   // Step-down window code to millivolts; both step-down outputs share it
   function automatic logic [6:0] decodeBuckWindow(input logic [1:0] code);
      case (code)
         2'h0: return 7'h1E;
         2'h1: return 7'h32;
         2'h2: return 7'h46;
         2'h3: return 7'h5A;
         default: return 7'h00;
      endcase
   endfunction

   // Monitor level code to tens of millivolts; code 7 repeats the top level
   function automatic logic [7:0] decodeMonLevel(input logic [2:0] code);
      case (code)
         3'h0: return 8'h41;
         3'h1: return 8'h50;
         3'h2: return 8'h64;
         3'h3: return 8'h6E;
         3'h4: return 8'h78;
         3'h5: return 8'h82;
         3'h6, 3'h7: return 8'hB4;
         default: return 8'h00;
      endcase
   endfunction

   // Analog supply level bit to tens of millivolts
   function automatic logic [8:0] decodeAnaLevel(input logic sel);
      return sel ? 9'h1F4 : 9'h14A;
   endfunction

   // Internal divider on for every level code but zero, which leaves the input high impedance
   function automatic logic dividerOn(input logic [2:0] code);
      return code != 3'h0;
   endfunction

   // Bits that software and the default image may set; reserved bits stay zero
   function automatic logic [7:0] wrMask(input logic [7:0] idx);
      case (idx)
         MON1_LEVEL_IDX: return MON1_MASK;
         GOOD_CTRL_IDX: return GOOD_CTRL_MASK;
         default: return 8'hFF;
      endcase
   endfunction

   // Read data of one register word; unmapped and unaligned places read zero
   function automatic logic [31:0] readWord(input pgtc_state_t st, input logic [ADDR_W-1:0] addr);
      logic [7:0] val;
      val = 8'h00;
      if (addr[1:0] == 2'b00) begin
         case (addr[ADDR_W-1:2])
            MON1_LEVEL_IDX: val = st.mon1;
            MON2_SUPPLY_IDX: val = st.mon2Supply;
            CONV_WINDOW_IDX: val = st.convWindow;
            GOOD_CTRL_IDX: val = st.goodCtrl;
            OTP_CTRL_IDX: val = {6'h00, st.otpDone, st.reloadReq};
            default: val = 8'h00;
         endcase
      end
      return {24'h00_0000, val};
   endfunction

   // Control register bits to the power-good output controls; bit 5 is reserved
   function automatic pgtc_good_t decodeGood(input logic [7:0] ctrl);
      pgtc_good_t g;
      g.goodBBehaviour = ctrl[GOOD_B_BEH_POS];
      g.goodBLatchedGating = ctrl[GOOD_B_GATE_POS];
      g.goodBPolarity = ctrl[GOOD_B_POL_POS];
      g.goodABehaviour = ctrl[GOOD_A_BEH_POS];
      g.goodALatchedGating = ctrl[GOOD_A_GATE_POS];
      g.goodADriveType = ctrl[GOOD_A_DRV_POS];
      g.goodAPolarity = ctrl[GOOD_A_POL_POS];
      return g;
   endfunction

   // Pin enable: push-pull always drives, open drain drives only its low level
   function automatic logic pinEnable(input logic openDrain, input logic level);
      return !openDrain || !level;
   endfunction

   // Next-state logic: bus, OTP load, decoded outputs
   always_comb begin
      pgtc_state_t s;
      s = state_q;
      // Two-flop synchroniser for the asynchronous image-valid level
      s.otpValidSync1 = otpValid;
      s.otpValidSync2 = state_q.otpValidSync1;
      s.rdData = 32'h0000_0000;
      // Load the OTP defaults once the image is valid, or on software request
      // The load wins over a bus write in the same cycle, so such a write is lost
      if ((!state_q.otpDone || state_q.reloadReq) && state_q.otpValidSync2) begin
         s.mon1 = otpImage.mon1 & wrMask(MON1_LEVEL_IDX);
         s.mon2Supply = otpImage.mon2Supply;
         s.convWindow = otpImage.convWindow;
         s.goodCtrl = otpImage.goodCtrl & wrMask(GOOD_CTRL_IDX);
         s.otpDone = 1'b1;
         s.reloadReq = 1'b0;
      end else if (busReq.wr) begin
         // Register writes; unmapped or unaligned places change nothing
         if (hitIdx(busReq.addr, MON1_LEVEL_IDX)) begin
            s.mon1 = busReq.wdata[7:0] & wrMask(MON1_LEVEL_IDX);
         end
         if (hitIdx(busReq.addr, MON2_SUPPLY_IDX)) begin
            s.mon2Supply = busReq.wdata[7:0];
         end
         if (hitIdx(busReq.addr, CONV_WINDOW_IDX)) begin
            s.convWindow = busReq.wdata[7:0];
         end
         if (hitIdx(busReq.addr, GOOD_CTRL_IDX)) begin
            s.goodCtrl = busReq.wdata[7:0] & wrMask(GOOD_CTRL_IDX);
         end
         // Software reload request; the load itself clears it again
         if (hitIdx(busReq.addr, OTP_CTRL_IDX)) begin
            s.reloadReq = busReq.wdata[0];
         end
      end
      // Register reads, answered in the next cycle; unmapped reads return zero
      if (busReq.rd) begin
         s.rdData = readWord(state_q, busReq.addr);
      end
      // Field decode for the comparators
      s.analog.mon1WindowWidth = state_q.mon1[WIN_LO+:2];
      s.analog.mon1NominalLevel = state_q.mon1[2:0];
      s.analog.mon1DividerEn = dividerOn(state_q.mon1[2:0]);
      s.analog.analogSupplyWindowWidth = state_q.mon2Supply[HI_WIN_LO+:2];
      s.analog.analogSupplyNominalLevel = state_q.mon2Supply[ANA_LEVEL_POS];
      s.analog.mon2WindowWidth = state_q.mon2Supply[WIN_LO+:2];
      s.analog.mon2NominalLevel = state_q.mon2Supply[2:0];
      s.analog.mon2DividerEn = dividerOn(state_q.mon2Supply[2:0]);
      s.analog.boostWindowWidth = state_q.convWindow[HI_WIN_LO+:2];
      s.analog.boostLevel = state_q.convWindow[BOOST_LEVEL_LO+:2];
      s.analog.stepDownBWindowWidth = state_q.convWindow[B_WIN_LO+:2];
      s.analog.stepDownAWindowWidth = state_q.convWindow[A_WIN_LO+:2];
      // Trim values in physical units
      s.mon1Win = decodeMonWindow(state_q.mon1[WIN_LO+:2]);
      s.mon1Lvl = decodeMonLevel(state_q.mon1[2:0]);
      s.mon2Win = decodeMonWindow(state_q.mon2Supply[WIN_LO+:2]);
      s.mon2Lvl = decodeMonLevel(state_q.mon2Supply[2:0]);
      s.anaWin = decodeAnaWindow(state_q.mon2Supply[HI_WIN_LO+:2]);
      s.anaLvl = decodeAnaLevel(state_q.mon2Supply[ANA_LEVEL_POS]);
      s.boostWin = decodeBoostWindow(state_q.convWindow[HI_WIN_LO+:2]);
      s.bWin = decodeBuckWindow(state_q.convWindow[B_WIN_LO+:2]);
      s.aWin = decodeBuckWindow(state_q.convWindow[A_WIN_LO+:2]);
      // Control bits
      s.good = decodeGood(state_q.goodCtrl);
      // Pin levels; open drain only drives while the level is low
      s.goodA = goodLevel(goodAValid, state_q.goodCtrl[GOOD_A_POL_POS]);
      s.goodB = goodLevel(goodBValid, state_q.goodCtrl[GOOD_B_POL_POS]);
      s.goodAOe = pinEnable(state_q.goodCtrl[GOOD_A_DRV_POS], s.goodA);
      state_d = s;
   end

   // State register with synchronous reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= '0;
         state_q.mon1 <= MON1_LEVEL_RST;
         state_q.mon2Supply <= MON2_SUPPLY_RST;
         state_q.convWindow <= CONV_WINDOW_RST;
         state_q.goodCtrl <= GOOD_CTRL_RST;
         // Pin A starts as open drain, matching the control register's reset value
         state_q.good.goodADriveType <= 1'b1;
         state_q.goodAOe <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from the state register
   assign rdData = state_q.rdData;
   assign analogCfg = state_q.analog;
   assign goodCfg = state_q.good;
   assign mon1WindowPct = state_q.mon1Win;
   assign mon1Level10mV = state_q.mon1Lvl;
   assign mon2WindowPct = state_q.mon2Win;
   assign mon2Level10mV = state_q.mon2Lvl;
   assign anaWindowPct = state_q.anaWin;
   assign anaLevel10mV = state_q.anaLvl;
   assign boostWindowPct = state_q.boostWin;
   assign stepDownBWindowMv = state_q.bWin;
   assign stepDownAWindowMv = state_q.aWin;
   assign goodOutputA = state_q.goodA;
   assign goodOutputB = state_q.goodB;
   assign goodOutputAOe = state_q.goodAOe;
   assign otpLoaded = state_q.otpDone;
endmodule

// ### pgtc_assertions.sv
`timescale 1ns/10ps
module pgtc_assertions
   import pgtc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire pgtc_pkg::pgtc_analog_t analogCfg,
   input wire pgtc_pkg::pgtc_good_t goodCfg,
   input wire logic goodAValid,
   input wire logic goodBValid,
   input wire logic [6:0] mon1WindowPct,
   input wire logic [6:0] anaWindowPct,
   input wire logic [8:0] anaLevel10mV,
   input wire logic [6:0] stepDownAWindowMv,
   input wire logic goodOutputA,
   input wire logic goodOutputB,
   input wire logic goodOutputAOe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Two clean cycles since reset, so registered outputs carry real values
   sequence settled;
      !$past(rst) && !$past(rst, 2);
   endsequence
   // Pins follow the valid input of the previous cycle through polarity
   pol_a_a: assert property (settled |-> goodOutputA == ($past(goodAValid) ^ goodCfg.goodAPolarity))
      else $error("pin A polarity mismatch");
   pol_b_a: assert property (settled |-> goodOutputB == ($past(goodBValid) ^ goodCfg.goodBPolarity))
      else $error("pin B polarity mismatch");
   divider_en_a: assert property (analogCfg.mon1DividerEn == (analogCfg.mon1NominalLevel != 3'h0) &&
      analogCfg.mon2DividerEn == (analogCfg.mon2NominalLevel != 3'h0)) else $error("divider enable wrong");
   mon_window_a: assert property (settled |-> mon1WindowPct ==
      (analogCfg.mon1WindowWidth == 2'h3 ? 7'd6 : 7'd2 + 7'(analogCfg.mon1WindowWidth))) else $error("mon1 window");
   ana_window_a: assert property (settled |-> anaWindowPct ==
      (analogCfg.analogSupplyWindowWidth[1] ? 7'd10 : 7'd4 + 7'(analogCfg.analogSupplyWindowWidth[0])))
      else $error("supply window");
   ana_level_a: assert property (settled |-> anaLevel10mV ==
      (analogCfg.analogSupplyNominalLevel ? 9'd500 : 9'd330)) else $error("supply level");
   step_window_a: assert property (settled |-> stepDownAWindowMv ==
      7'd30 + 7'd20 * 7'(analogCfg.stepDownAWindowWidth)) else $error("step-down A window");
   drive_oe_a: assert property (settled |-> goodOutputAOe == (!goodCfg.goodADriveType || !goodOutputA))
      else $error("pin A enable wrong");
endmodule

bind pgtc_regs pgtc_assertions i_chk (.core_clk, .rst, .analogCfg, .goodCfg, .goodAValid, .goodBValid,
   .mon1WindowPct, .anaWindowPct, .anaLevel10mV, .stepDownAWindowMv, .goodOutputA, .goodOutputB, .goodOutputAOe);

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
   import pgtc_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   pgtc_bus_req_t busReq = '0;
   pgtc_otp_t otpImage = {8'h1A, 8'hB5, 8'h6E, 8'h93};
   logic otpValid = 1'b0;
   logic goodAValid = 1'b0;
   logic goodBValid = 1'b0;
   logic [31:0] rdData;
   pgtc_analog_t analogCfg;
   pgtc_good_t goodCfg;
   logic [6:0] mon1WindowPct, mon2WindowPct, anaWindowPct, boostWindowPct, stepDownBWindowMv, stepDownAWindowMv;
   logic [7:0] mon1Level10mV, mon2Level10mV;
   logic [8:0] anaLevel10mV;
   logic goodOutputA, goodOutputB, goodOutputAOe, otpLoaded;
   logic [2:0] c;
   logic [1:0] bw;
   int errorCnt = 0;
   int testsRun = 0;
   int cycles = 0;
   int lvlTab [8] = '{65, 80, 100, 110, 120, 130, 180, 180};

   pgtc_regs i_dut (.core_clk, .rst, .busReq, .rdData, .otpImage, .otpValid, .goodAValid, .goodBValid,
      .analogCfg, .goodCfg, .mon1WindowPct, .mon1Level10mV, .mon2WindowPct, .mon2Level10mV, .anaWindowPct,
      .anaLevel10mV, .boostWindowPct, .stepDownBWindowMv, .stepDownAWindowMv, .goodOutputA, .goodOutputB,
      .goodOutputAOe, .otpLoaded);

   // Clock and hang guard
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errorCnt++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus cycles start right after a rising edge
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      busReq.addr <= a;
      busReq.wdata <= {24'h0, d};
      busReq.wr <= 1'b1;
      @(posedge core_clk);
      busReq.wr <= 1'b0;
      @(posedge core_clk); // Idle edge so the next call never drives the strobe twice at once
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge core_clk);
      busReq.rd <= 1'b0;
      #1 chk(rdData, {24'h0, e});
      @(posedge core_clk);
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // Values before and after the default image lands
      rd(10'h050, 8'h00);
      rd(10'h054, 8'h00);
      rd(10'h058, 8'h00);
      rd(10'h05C, 8'h02);
      otpValid <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1 chk(otpLoaded, 1);
      @(posedge core_clk);
      rd(10'h050, 8'h1A);
      rd(10'h054, 8'hB5);
      rd(10'h058, 8'h6E);
      rd(10'h05C, 8'h93);
      // Reserved bits, field positions, unmapped places
      wr(10'h050, 8'hFF);
      wr(10'h05C, 8'hFF);
      rd(10'h050, 8'h1F);
      rd(10'h05C, 8'hDF);
      #1 chk(goodCfg, 7'h7F);
      @(posedge core_clk);
      wr(10'h05C, 8'hA4);
      @(posedge core_clk);
      #1 chk(goodCfg, 7'h44);
      @(posedge core_clk);
      wr(10'h060, 8'hFF);
      wr(10'h055, 8'hFF);
      rd(10'h060, 8'h00);
      rd(10'h055, 8'h00);
      rd(10'h054, 8'hB5);
      // Every code of every level and window field
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         bw = c[1:0] + 2'h1;
         wr(10'h050, {3'h0, c[1:0], c});
         wr(10'h054, {c[1:0], c[0], c[1:0], c});
         wr(10'h058, {c[1:0], c[2:1], bw, ~c[1:0]});
         @(posedge core_clk);
         #1 chk(mon1WindowPct, c[1:0] == 2'h3 ? 6 : 2 + c[1:0]);
         if (c != 3'h7) chk(mon1Level10mV, lvlTab[c]);
         chk({analogCfg.mon1DividerEn, analogCfg.mon2DividerEn}, c != 3'h0 ? 3 : 0);
         chk(anaWindowPct, c[1] ? 10 : 4 + c[0]);
         chk(anaLevel10mV, c[0] ? 500 : 330);
         chk(mon2WindowPct, c[1:0] == 2'h3 ? 6 : 2 + c[1:0]);
         chk(mon2Level10mV, lvlTab[c]);
         chk(boostWindowPct, 2 + 2 * c[1:0]);
         chk(stepDownBWindowMv, 30 + 20 * bw);
         chk(stepDownAWindowMv, 30 + 20 * (3 - c[1:0]));
         chk(analogCfg.boostLevel, c[2:1]);
         chk(analogCfg, {c[1:0], c, (c != 3'h0), c[1:0], c[0], c[1:0], c, (c != 3'h0), c[1:0], c[2:1], bw, ~c[1:0]});
         @(posedge core_clk);
      end
      rd(10'h058, 8'hF0);
      // Pin polarity and drive type
      goodAValid <= 1'b1;
      wr(10'h05C, 8'h11);
      @(posedge core_clk);
      #1 chk({goodOutputA, goodOutputB, goodOutputAOe}, 3'b011);
      @(posedge core_clk);
      wr(10'h05C, 8'h02);
      @(posedge core_clk);
      #1 chk({goodOutputA, goodOutputB, goodOutputAOe}, 3'b100);
      @(posedge core_clk);
      goodAValid <= 1'b0;
      goodBValid <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk({goodOutputA, goodOutputB, goodOutputAOe}, 3'b011);
      // Software reload brings the default image back over written values
      @(posedge core_clk);
      wr(10'h070, 8'h01);
      rd(10'h050, 8'h1A);
      rd(10'h05C, 8'h93);
      rd(10'h070, 8'h02);
      final_report();
   end
endmodule
